// ===== hdl/cxp_regs.svh
// Constants of the crosspoint serial configuration port.
// Included by the package; definitions only.
`ifndef CXP_REGS_SVH
`define CXP_REGS_SVH

// Switch geometry
`define CXP_NUM_OUT 8
`define CXP_SEL_W 4
`define CXP_FIELD_W 5
`define CXP_FRAME_W 40
`define CXP_WORD_W 8

// Full-frame field layout, per output
`define CXP_F_SEL_LSB 0
`define CXP_F_OFF_POS 4

// Addressed word layout
`define CXP_W_OUT_LSB 0
`define CXP_W_OUT_MSB 2
`define CXP_W_IN_LSB 3
`define CXP_W_IN_MSB 6
`define CXP_W_OFF_POS 7

// Live register values
`define CXP_SEL_FIRST 32'h0000_0000
`define CXP_ALL_OFF 8'hFF
`define CXP_ALL_ON 8'h00

// Bit counter
`define CXP_CNT_W 7
`define CXP_CNT_ZERO 7'h00
`define CXP_CNT_ONE 7'h01
`define CXP_CNT_MAX 7'h7F
`define CXP_CNT_WORD 7'h08

// Synchronised pin bus
`define CXP_SYNC_W 7
`define CXP_PIN_CLK 0
`define CXP_PIN_SELN 1
`define CXP_PIN_DIN 2
`define CXP_PIN_MODE 3
`define CXP_PIN_APPLY 4
`define CXP_PIN_RST 5
`define CXP_PIN_ALL_TO_FIRST_INPUT 6
`define CXP_SYNC_RST 7'h02

`endif

// ===== hdl/cxp_pkg.sv
// Types of the crosspoint serial configuration port.
// Needs cxp_regs.svh on the include path.
`include "cxp_regs.svh"

package cxp_pkg;

   typedef enum logic [1:0] {CXP_IDLE, CXP_ARMED, CXP_SHIFT, CXP_CLOSE} cxp_phase_t;

   typedef struct packed {
      cxp_phase_t phase;
      logic mode_addr;
      logic [`CXP_CNT_W-1:0] cnt;
      logic [`CXP_FRAME_W-1:0] stage;
      logic [`CXP_WORD_W-1:0] word;
      logic pending;
      logic ser_out;
      logic clk_d;
      logic apply_d;
   } cxp_port_st_t;

   typedef struct packed {
      logic [`CXP_SYNC_W-1:0] s1;
      logic [`CXP_SYNC_W-1:0] s2;
   } cxp_sync_st_t;

   typedef struct packed {
      logic [`CXP_NUM_OUT*`CXP_SEL_W-1:0] sel;
      logic [`CXP_NUM_OUT-1:0] off;
   } cxp_live_st_t;

endpackage

// ===== hdl/cxp_sync.sv
// Two-flop synchroniser for every pin of the configuration port.
// Pins are asynchronous to sys_clk; only s2 is read outside.
`timescale 1ns/1ps
`include "cxp_regs.svh"

module cxp_sync
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Pins
   input wire logic [`CXP_SYNC_W-1:0] async_in,
   output logic [`CXP_SYNC_W-1:0] sync_out
);

   cxp_pkg::cxp_sync_st_t st_reg;
   cxp_pkg::cxp_sync_st_t st_next;

   always_comb
   begin
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
   end

   // Select rests high so nothing looks like a transfer at reset
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg.s1 <= `CXP_SYNC_RST;
         st_reg.s2 <= `CXP_SYNC_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.s2;

endmodule

// ===== hdl/cxp_live_bank.sv
// Live switch registers that steer the crosspoint matrix.
// Loaded from the staging frame on load; overrides from level inputs.
`timescale 1ns/1ps
`include "cxp_regs.svh"

module cxp_live_bank
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Control
   input wire logic load,
   input wire logic force_off,
   input wire logic force_first,
   input wire logic [`CXP_FRAME_W-1:0] staged,
   // Live state
   output logic [`CXP_NUM_OUT*`CXP_SEL_W-1:0] live_sel,
   output logic [`CXP_NUM_OUT-1:0] live_off
);

   cxp_pkg::cxp_live_st_t st_reg;
   cxp_pkg::cxp_live_st_t st_next;
   logic [`CXP_NUM_OUT*`CXP_SEL_W-1:0] unp_sel;
   logic [`CXP_NUM_OUT-1:0] unp_off;

   genvar gi;
   generate
      for (gi = 0; gi < `CXP_NUM_OUT; gi = gi + 1)
      begin : g_field
         assign unp_sel[gi*`CXP_SEL_W +: `CXP_SEL_W] =
            staged[gi*`CXP_FIELD_W+`CXP_F_SEL_LSB +: `CXP_SEL_W];
         assign unp_off[gi] = staged[gi*`CXP_FIELD_W+`CXP_F_OFF_POS];
      end
   endgenerate

   always_comb
   begin
      st_next = st_reg;
      if (force_off)
      begin
         st_next.sel = `CXP_SEL_FIRST;
         st_next.off = `CXP_ALL_OFF;
      end
      else if (force_first)
      begin
         st_next.sel = `CXP_SEL_FIRST;
         st_next.off = `CXP_ALL_ON;
      end
      else if (load)
      begin
         st_next.sel = unp_sel;
         st_next.off = unp_off;
      end
   end

   // Power-up state matches the reset pin: all outputs off
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg.sel <= `CXP_SEL_FIRST;
         st_reg.off <= `CXP_ALL_OFF;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign live_sel = st_reg.sel;
   assign live_off = st_reg.off;

endmodule

// ===== hdl/cxp_port.sv
// Serial configuration port of a 16-input, 8-output crosspoint.
// All pins are asynchronous and oversampled by sys_clk at 100 MHz;
// the serial clock must stay well below a quarter of that rate.
//
// Function
// - Frame bits 30-34 set output 6, bits 35-39 output 7, bit 39 last.
// - Addressed 8-bit word changes only the named output's staging field.
// - Word: bits 0-2 output, 3-6 input, bit 7 off; bit 0 first.
// - First rising edge after select falls arms; next falling edge captures.
// - Daisy chaining through serial out works only in full-frame mode.
// - Serial out shows old shift contents; after 40 bits, new bits pass.
// - Apply pulse activates staged configuration; shared apply switches together.
// - Reset level loads input 0 everywhere and turns all outputs off.
// - Broadcast level, with reset low, turns all outputs on, connected to input 0.
// - Reset and broadcast act on level, apart from serial bus, overwriting.
// - While select is high, data and clock activity is ignored, except the rising edge that closes a transfer.
// - Serial data is sampled only on falling serial clock edges.
// - Only an apply pulse moves new data live; apply without data does nothing.
// - Mode low takes a 40-bit frame, five bits per output in order.
`timescale 1ns/1ps
`include "cxp_regs.svh"

module cxp_port
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Serial link pins
   input wire logic sel_n,
   input wire logic link_clk,
   input wire logic ser_in,
   output logic ser_out,
   // Control pins
   input wire logic mode_addr,
   input wire logic apply,
   input wire logic xpt_reset,
   input wire logic all_to_first_input,
   // Live switch state
   output logic [`CXP_NUM_OUT*`CXP_SEL_W-1:0] out_input_sel,
   output logic [`CXP_NUM_OUT-1:0] out_off
);

   cxp_pkg::cxp_port_st_t st_reg;
   cxp_pkg::cxp_port_st_t st_next;
   logic [`CXP_SYNC_W-1:0] pins;
   logic [`CXP_SYNC_W-1:0] pins_s;
   logic clk_s;
   logic sel_hi;
   logic din_s;
   logic mode_s;
   logic rst_s;
   logic all_to_first_input_s;
   logic clk_rise;
   logic clk_fall;
   logic apply_rise;
   logic apply_go;
   logic commit;
   logic addr_commit;
   logic set_pending;
   logic [`CXP_FIELD_W-1:0] word_field;

   assign pins[`CXP_PIN_CLK] = link_clk;
   assign pins[`CXP_PIN_SELN] = sel_n;
   assign pins[`CXP_PIN_DIN] = ser_in;
   assign pins[`CXP_PIN_MODE] = mode_addr;
   assign pins[`CXP_PIN_APPLY] = apply;
   assign pins[`CXP_PIN_RST] = xpt_reset;
   assign pins[`CXP_PIN_ALL_TO_FIRST_INPUT] = all_to_first_input;

   cxp_sync u_sync
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .async_in(pins),
      .sync_out(pins_s)
   );

   assign clk_s = pins_s[`CXP_PIN_CLK];
   assign sel_hi = pins_s[`CXP_PIN_SELN];
   assign din_s = pins_s[`CXP_PIN_DIN];
   assign mode_s = pins_s[`CXP_PIN_MODE];
   assign rst_s = pins_s[`CXP_PIN_RST];
   assign all_to_first_input_s = pins_s[`CXP_PIN_ALL_TO_FIRST_INPUT];

   // Edges of the serial clock and apply pin seen at sys_clk rate
   assign clk_rise = clk_s & ~st_reg.clk_d;
   assign clk_fall = ~clk_s & st_reg.clk_d;
   assign apply_rise = pins_s[`CXP_PIN_APPLY] & ~st_reg.apply_d;

   // Transfer closes on the rising edge after select returns high
   assign commit = (st_reg.phase == cxp_pkg::CXP_CLOSE) && clk_rise;
   assign addr_commit = commit && st_reg.mode_addr && (st_reg.cnt >= `CXP_CNT_WORD);
   assign set_pending = commit && (st_reg.mode_addr ? (st_reg.cnt >= `CXP_CNT_WORD)
                                                    : (st_reg.cnt != `CXP_CNT_ZERO));

   // Overrides block apply, reset first
   assign apply_go = apply_rise && st_reg.pending && !rst_s && !all_to_first_input_s;

   assign word_field = {st_reg.word[`CXP_W_OFF_POS],
                        st_reg.word[`CXP_W_IN_MSB:`CXP_W_IN_LSB]};

   always_comb
   begin
      st_next = st_reg;
      st_next.clk_d = clk_s;
      st_next.apply_d = pins_s[`CXP_PIN_APPLY];
      case (st_reg.phase)
         cxp_pkg::CXP_IDLE:
         begin
            if (!sel_hi)
            begin
               st_next.phase = cxp_pkg::CXP_ARMED;
            end
         end
         cxp_pkg::CXP_ARMED:
         begin
            if (sel_hi)
            begin
               st_next.phase = cxp_pkg::CXP_IDLE;
            end
            else if (clk_rise)
            begin
               st_next.phase = cxp_pkg::CXP_SHIFT;
               st_next.mode_addr = mode_s;
               st_next.cnt = `CXP_CNT_ZERO;
            end
         end
         cxp_pkg::CXP_SHIFT:
         begin
            if (sel_hi)
            begin
               st_next.phase = cxp_pkg::CXP_CLOSE;
            end
            else if (clk_fall)
            begin
               if (st_reg.cnt != `CXP_CNT_MAX)
               begin
                  st_next.cnt = st_reg.cnt + `CXP_CNT_ONE;
               end
               st_next.word = {din_s, st_reg.word[`CXP_WORD_W-1:1]};
               if (!st_reg.mode_addr)
               begin
                  // Oldest bit leaves first, so chains pass frames intact
                  st_next.ser_out = st_reg.stage[0];
                  st_next.stage = {din_s, st_reg.stage[`CXP_FRAME_W-1:1]};
               end
            end
         end
         cxp_pkg::CXP_CLOSE:
         begin
            if (clk_rise)
            begin
               st_next.phase = cxp_pkg::CXP_IDLE;
            end
         end
         default:
         begin
            st_next.phase = cxp_pkg::CXP_IDLE;
         end
      endcase
      if (addr_commit)
      begin
         for (int i = 0; i < `CXP_NUM_OUT; i++)
         begin
            if (st_reg.word[`CXP_W_OUT_MSB:`CXP_W_OUT_LSB] == i[2:0])
            begin
               st_next.stage[i*`CXP_FIELD_W +: `CXP_FIELD_W] = word_field;
            end
         end
      end
      // New data wins over a clearing apply in the same cycle
      if (set_pending)
      begin
         st_next.pending = 1'b1;
      end
      else if (apply_go)
      begin
         st_next.pending = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg.phase <= cxp_pkg::CXP_IDLE;
         st_reg.mode_addr <= 1'b0;
         st_reg.cnt <= `CXP_CNT_ZERO;
         st_reg.stage <= '0;
         st_reg.word <= '0;
         st_reg.pending <= 1'b0;
         st_reg.ser_out <= 1'b0;
         st_reg.clk_d <= 1'b0;
         st_reg.apply_d <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign ser_out = st_reg.ser_out;

   cxp_live_bank u_live
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .load(apply_go),
      .force_off(rst_s),
      .force_first(all_to_first_input_s),
      .staged(st_reg.stage),
      .live_sel(out_input_sel),
      .live_off(out_off)
   );

   // Checking helpers
   logic [`CXP_NUM_OUT*`CXP_SEL_W-1:0] exp_sel;
   logic [`CXP_NUM_OUT-1:0] exp_off;
   logic [`CXP_FRAME_W-1:0] fld_mask;
   logic [`CXP_FRAME_W-1:0] fld_val;

   genvar gk;
   generate
      for (gk = 0; gk < `CXP_NUM_OUT; gk = gk + 1)
      begin : g_exp
         assign exp_sel[gk*`CXP_SEL_W +: `CXP_SEL_W] =
            st_reg.stage[gk*`CXP_FIELD_W +: `CXP_SEL_W];
         assign exp_off[gk] = st_reg.stage[gk*`CXP_FIELD_W+`CXP_F_OFF_POS];
         assign fld_mask[gk*`CXP_FIELD_W +: `CXP_FIELD_W] =
            (st_reg.word[`CXP_W_OUT_MSB:`CXP_W_OUT_LSB] == gk) ? '1 : '0;
         assign fld_val[gk*`CXP_FIELD_W +: `CXP_FIELD_W] =
            (st_reg.word[`CXP_W_OUT_MSB:`CXP_W_OUT_LSB] == gk) ? word_field : '0;
      end
   endgenerate

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_open;
      st_reg.phase == cxp_pkg::CXP_IDLE && !sel_hi;
   endsequence

   sequence s_arm;
      st_reg.phase == cxp_pkg::CXP_ARMED && !sel_hi && clk_rise;
   endsequence

   a_open_arm: assert property (s_open |=> st_reg.phase == cxp_pkg::CXP_ARMED)
      else $error("select low did not arm capture");

   a_arm_then_shift: assert property (s_arm |=>
      st_reg.phase == cxp_pkg::CXP_SHIFT && st_reg.cnt == `CXP_CNT_ZERO)
      else $error("capture not armed by first rising edge");

   a_capture_fall: assert property ($changed(st_reg.cnt) && st_reg.cnt != `CXP_CNT_ZERO |->
      $past(clk_fall) && $past(st_reg.phase == cxp_pkg::CXP_SHIFT))
      else $error("bit counted without falling edge in shift");

   a_sel_ignore: assert property (sel_hi && st_reg.phase == cxp_pkg::CXP_IDLE |=>
      $stable(st_reg.stage) && $stable(st_reg.word) && $stable(st_reg.cnt))
      else $error("activity taken while select high");

   a_frame_shift: assert property (st_reg.phase == cxp_pkg::CXP_SHIFT && !sel_hi
      && clk_fall && !st_reg.mode_addr |=>
      st_reg.stage == {$past(din_s), $past(st_reg.stage[`CXP_FRAME_W-1:1])})
      else $error("frame bit not shifted in at top");

   a_chain_out: assert property (st_reg.phase == cxp_pkg::CXP_SHIFT && !sel_hi
      && clk_fall && !st_reg.mode_addr |=>
      ser_out == $past(st_reg.stage[0]))
      else $error("serial out not oldest stage bit");

   a_addr_no_chain: assert property (st_reg.mode_addr && st_reg.phase != cxp_pkg::CXP_ARMED |=>
      $stable(ser_out))
      else $error("serial out moved in addressed mode");

   a_addr_one_field: assert property (addr_commit |=>
      ((st_reg.stage ^ $past(st_reg.stage)) & ~$past(fld_mask)) == '0
      && (st_reg.stage & $past(fld_mask)) == $past(fld_val))
      else $error("addressed word touched wrong field");

   a_apply_load: assert property (apply_go |=>
      out_input_sel == $past(exp_sel) && out_off == $past(exp_off))
      else $error("apply did not load staged frame");

   a_apply_noop: assert property (apply_rise && !st_reg.pending && !rst_s && !all_to_first_input_s |=>
      $stable(out_input_sel) && $stable(out_off))
      else $error("apply without new data changed outputs");

   a_reset_off: assert property (rst_s |=>
      out_off == `CXP_ALL_OFF && out_input_sel == `CXP_SEL_FIRST)
      else $error("reset level did not force all off");

   a_all_to_first_input_on: assert property (all_to_first_input_s && !rst_s |=>
      out_off == `CXP_ALL_ON && out_input_sel == `CXP_SEL_FIRST)
      else $error("broadcast did not connect all to input 0");

   a_level_hold: assert property (rst_s [*3] |->
      !apply_go && out_off == `CXP_ALL_OFF)
      else $error("reset level not held against apply");

   a_close_commit: assert property (st_reg.phase == cxp_pkg::CXP_CLOSE && clk_rise
      && !st_reg.mode_addr && st_reg.cnt != `CXP_CNT_ZERO |=>
      st_reg.pending && st_reg.phase == cxp_pkg::CXP_IDLE)
      else $error("frame not committed on closing edge");

endmodule

// ===== sim/cxp_ctl_model.sv
// Controller model that drives the serial configuration pins.
// Assumes the port oversamples these pins with a much faster clock.
`timescale 1ns/1ps

module cxp_ctl_model
(
   // Serial link
   output logic sel_n,
   output logic link_clk,
   output logic ser_in,
   output logic mode_addr,
   // Daisy chain return
   input wire logic ser_out
);
   logic so_seen [0:79];

   initial
   begin
      sel_n = 1'b1;
      link_clk = 1'b0;
      ser_in = 1'b1;
      mode_addr = 1'b0;
   end

   // Bit 0 goes first; without close the committing edge is left out
   // Callers start on a falling sys_clk edge; the offset keeps pin edges off sys_clk edges
   task automatic xfer(input logic [79:0] bits, input int n, input logic md, input logic close);
      #1.25;
      mode_addr = md;
      #62.5 sel_n = 1'b0;
      #62.5 link_clk = 1'b1;
      for (int k = 0; k < n; k++)
      begin
         ser_in = bits[k];
         #62.5 link_clk = 1'b0;
         #62.5 so_seen[k] = ser_out;
         if (k < n - 1)
            link_clk = 1'b1;
      end
      sel_n = 1'b1;
      ser_in = ~ser_in;
      #62.5 link_clk = close;
      #62.5 link_clk = 1'b0;
   endtask

   // Clock and data wiggle while deselected
   task automatic noise();
      #1.25;
      for (int k = 0; k < 6; k++)
      begin
         ser_in = k[0];
         #62.5 link_clk = ~link_clk;
      end
   endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the crosspoint serial configuration port.
// Expects cxp_regs.svh on the include path and the controller model.
`timescale 1ns/1ps
`include "cxp_regs.svh"
`define CHK(nm, e, g) \
   begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module testbench;
   logic sys_clk;
   logic arst_n;
   logic sel_n;
   logic link_clk;
   logic ser_in;
   logic ser_out;
   logic mode_addr;
   logic apply;
   logic xpt_reset;
   logic all_to_first_input;
   logic [31:0] out_input_sel;
   logic [7:0] out_off;
   logic [31:0] exp_sel;
   logic [7:0] exp_off;
   int miscompares = 0;
   int compares = 0;
   localparam logic [39:0] F1 = 40'hA53C96E17B;
   localparam logic [39:0] FA = 40'h5AC3691E84;
   localparam logic [39:0] FB = 40'h3E1D72B94C;

   cxp_ctl_model i_ctl (.sel_n(sel_n), .link_clk(link_clk), .ser_in(ser_in),
      .mode_addr(mode_addr), .ser_out(ser_out));

   cxp_port i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .sel_n(sel_n), .link_clk(link_clk),
      .ser_in(ser_in), .ser_out(ser_out), .mode_addr(mode_addr), .apply(apply),
      .xpt_reset(xpt_reset), .all_to_first_input(all_to_first_input),
      .out_input_sel(out_input_sel), .out_off(out_off));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic expect_frame(input logic [39:0] f);
      for (int j = 0; j < 8; j++)
      begin
         exp_sel[4*j +: 4] = f[5*j +: 4];
         exp_off[j] = f[5*j + 4];
      end
   endtask

   task automatic check_live(input string nm);
      `CHK({nm, " sel"}, exp_sel, out_input_sel)
      `CHK({nm, " off"}, exp_off, out_off)
   endtask

   // Apply only after the transfer is closed; outputs settle in 3 cycles
   task automatic pulse_apply();
      @(negedge sys_clk) apply = 1'b1;
      repeat (3) @(negedge sys_clk);
      apply = 1'b0;
      repeat (6) @(negedge sys_clk);
   endtask

   task automatic t_reset_values();
      exp_sel = `CXP_SEL_FIRST;
      exp_off = `CXP_ALL_OFF;
      check_live("after reset");
      `CHK("ser_out reset", 1'b0, ser_out)
      $display("done t_reset_values");
   endtask

   task automatic t_full_frame();
      i_ctl.xfer({40'h0, F1}, 40, 1'b0, 1'b1);
      check_live("before apply");
      pulse_apply();
      expect_frame(F1);
      check_live("full frame");
      $display("done t_full_frame");
   endtask

   task automatic t_chain();
      i_ctl.xfer({FB, FA}, 80, 1'b0, 1'b1);
      for (int k = 0; k < 80; k++)
         `CHK("ser_out", (k < 40) ? F1[k] : FA[k-40], i_ctl.so_seen[k])
      pulse_apply();
      expect_frame(FB);
      check_live("chain");
      $display("done t_chain");
   endtask

   task automatic t_addressed();
      logic [7:0] w;
      logic held;
      for (int o = 0; o < 8; o += 7)
      begin
         w = {o[0], o[3:0] ^ 4'hA, o[2:0]};
         held = ser_out;
         i_ctl.xfer({72'h0, w}, 8, 1'b1, 1'b1);
         for (int k = 0; k < 8; k++)
            `CHK("ser_out addressed", held, i_ctl.so_seen[k])
         pulse_apply();
         exp_sel[4*o +: 4] = w[6:3];
         exp_off[o] = w[7];
         check_live("addressed");
      end
      $display("done t_addressed");
   endtask

   task automatic t_ignored();
      i_ctl.noise();
      pulse_apply();
      check_live("deselected");
      i_ctl.xfer({40'h0, FA}, 40, 1'b0, 1'b0);
      pulse_apply();
      check_live("unclosed");
      $display("done t_ignored");
   endtask

   task automatic t_overrides();
      @(negedge sys_clk) xpt_reset = 1'b1;
      repeat (5) @(negedge sys_clk);
      exp_sel = `CXP_SEL_FIRST;
      exp_off = `CXP_ALL_OFF;
      check_live("reset level");
      all_to_first_input = 1'b1;
      repeat (5) @(negedge sys_clk);
      check_live("reset wins");
      xpt_reset = 1'b0;
      repeat (5) @(negedge sys_clk);
      exp_off = `CXP_ALL_ON;
      check_live("broadcast");
      all_to_first_input = 1'b0;
      repeat (5) @(negedge sys_clk);
      check_live("released");
      pulse_apply();
      check_live("idle apply");
      $display("done t_overrides");
   endtask

   initial
   begin
      arst_n = 1'b0;
      apply = 1'b0;
      xpt_reset = 1'b0;
      all_to_first_input = 1'b0;
      repeat (20) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      t_reset_values();
      t_full_frame();
      t_chain();
      t_addressed();
      t_ignored();
      t_overrides();
      results();
   end

   // A hang counts as a mismatch
   initial
   begin
      #500000;
      miscompares++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end
endmodule
